/* File: design/mcs_regs.sv */
// Functional notes
// - Transmit command low nibble are interrupt masks
// - Masks cover underflow, collision, error, success
// - Transmit command bit 4 selects MII
// - Config1 bit 7 suppresses all receive interrupts
// - Receive enables map good..overflow to bits 5..0
// - Receive bits 0-3 also accept errored packets
// - Receive bits 7:6 select match mode
// - Two transmit status entries, bit 7 low new
// - Both full blocks further transmit status
// - Read of new status frees one entry
// - Transmit status bit layout underflow..old/new
// - Config2 bit 1 holds transmit while full
// - Config2 bit 0 skips successful status loads
// - Receive status locked until read clears it
// - Receive status bit layout overflow..old/new
// - Kept packets get status and count word
// - Word bit 7 abort, bit 8 fault
// - Reading fault status resets receive section
// - Status word layout independent of endianness
// - Register port uses select, strobes, six address lines
module mcs_regs
	import mcs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic register_port_select_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [MCS_ADDR_W-1:0] addr,
	input wire logic [MCS_DATA_W-1:0] command_status_bus_in,
	output logic [MCS_DATA_W-1:0] command_status_bus_out,
	output logic command_status_bus_oe,
	input wire logic receive_abort_in,
	input wire logic carrier_sense_in,
	input wire logic rx_irq_disable,
	input wire logic cfg_tx_hold_when_full,
	input wire logic cfg_skip_success_status,
	input wire logic tx_done,
	input wire logic [6:0] tx_done_status,
	input wire logic rx_done,
	input wire logic [6:0] rx_done_status,
	input wire logic [MCS_COUNT_W-1:0] rx_byte_count,
	input wire logic rx_fifo_fault,
	input wire logic rx_status_taken,
	input wire logic rx_status_taken_err,
	output logic mii_select,
	output logic test_mode,
	output logic [1:0] match_mode,
	output logic tx_start_allowed,
	output logic tx_status_full,
	output logic tx_irq,
	output logic rx_irq,
	output logic rx_discard,
	output logic [31:0] rx_status_word,
	output logic rx_status_word_valid,
	output logic rx_section_reset
);
	// ==========================================================
	// State
	// Register port, abort and carrier pins are synchronised; the port is slow next to ref_clk
	typedef struct packed {
		logic sel_n;
		logic rd_n;
		logic wr_n;
		logic abort;
		logic cs;
		logic [MCS_ADDR_W-1:0] addr;
		logic [MCS_DATA_W-1:0] data;
	} mcs_pins_t;

	typedef struct packed {
		mcs_pins_t s1;
		mcs_pins_t s2;
		mcs_bus_st_t bus;
		logic [MCS_ADDR_W-1:0] lat_addr;
		logic [MCS_DATA_W-1:0] lat_data;
		logic [7:0] tx_cmd;
		logic [7:0] rx_cmd;
		logic [MCS_DATA_W-1:0] dout;
		logic doe;
		logic abort_lat;
		logic tx_irq;
		logic rx_irq;
		logic rx_reset;
		logic tx_allow;
		logic tx_full;
		logic discard;
		logic [31:0] word;
		logic word_valid;
	} mcs_state_t;

	mcs_state_t st_ff;
	mcs_state_t nxt_st;
	mcs_pins_t pins_now;
	logic [7:0] tx_head;
	logic tx_full_w;
	logic [7:0] rx_stat;
	logic rx_disc_w;
	logic [31:0] rx_word_w;
	logic rx_word_v_w;
	logic rx_irq_hit;
	logic read_end;
	logic write_end;
	logic tx_pop;
	logic rx_clear;
	logic [3:0] tx_cond;

	// ==========================================================
	// Decoding used by read mux and read-side effects
	function automatic logic mcs_hit(input logic [MCS_ADDR_W-1:0] a,
		input logic [MCS_ADDR_W-1:0] reg_addr);
		mcs_hit = (a == reg_addr);
	endfunction : mcs_hit

	// Command addresses are shared with status, so reads there return status; other addresses read zero
	function automatic logic [MCS_DATA_W-1:0] mcs_read_mux(input logic [MCS_ADDR_W-1:0] a,
		input logic [7:0] txs, input logic [7:0] rxs);
		if (mcs_hit(a, MCS_ADDR_TX_STAT))
			mcs_read_mux = txs;
		else if (mcs_hit(a, MCS_ADDR_RX_STAT))
			mcs_read_mux = rxs;
		else
			mcs_read_mux = MCS_BUS_IDLE;
	endfunction : mcs_read_mux

	// ==========================================================
	// Pin capture
	assign pins_now = '{sel_n: register_port_select_n, rd_n: rd_n, wr_n: wr_n,
		abort: receive_abort_in, cs: carrier_sense_in, addr: addr,
		data: command_status_bus_in};

	// Strobe ends are taken from the synchronised copy only
	assign read_end = (st_ff.bus == MCS_BUS_READ) && st_ff.s2.rd_n;
	assign write_end = (st_ff.bus == MCS_BUS_WRITE) && st_ff.s2.wr_n;
	// Frees an entry only when the read really returned new status
	assign tx_pop = read_end && mcs_hit(st_ff.lat_addr, MCS_ADDR_TX_STAT)
		&& !tx_head[MCS_STAT_NEW_N];
	assign rx_clear = read_end && mcs_hit(st_ff.lat_addr, MCS_ADDR_RX_STAT);

	// Grouping of transmit events onto the four mask bits
	assign tx_cond[0] = tx_done_status[MCS_TXS_UNDERFLOW];
	assign tx_cond[1] = tx_done_status[MCS_TXS_COLL];
	assign tx_cond[2] = tx_done_status[MCS_TXS_COLL16] | tx_done_status[MCS_TXS_CARRIER]
		| tx_done_status[MCS_TXS_LATE];
	assign tx_cond[3] = tx_done_status[MCS_TXS_OK];

	// ==========================================================
	// Status holders
	mcs_tx_status u_tx_status (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.load(tx_done),
		.load_status(tx_done_status),
		.skip_success(cfg_skip_success_status),
		.pop(tx_pop),
		.head(tx_head),
		.full(tx_full_w)
	);

	mcs_rx_status u_rx_status (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.pkt_done(rx_done),
		.pkt_status(rx_done_status),
		.pkt_count(rx_byte_count),
		.abort_seen(st_ff.abort_lat),
		.fifo_fault(rx_fifo_fault),
		.rx_cmd(st_ff.rx_cmd),
		.clear(rx_clear),
		.stat_reg(rx_stat),
		.discard(rx_disc_w),
		.fifo_word(rx_word_w),
		.word_valid(rx_word_v_w),
		.irq_hit(rx_irq_hit)
	);

	// ==========================================================
	// Next state
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.s1 = pins_now;
		nxt_st.s2 = st_ff.s1;
		nxt_st.rx_reset = 1'b0;
		// Register port cycle tracking
		case (st_ff.bus)
			MCS_BUS_IDLE_ST:
			begin
				if (!st_ff.s2.sel_n && !st_ff.s2.rd_n)
					nxt_st.bus = MCS_BUS_READ;
				else if (!st_ff.s2.sel_n && !st_ff.s2.wr_n)
					nxt_st.bus = MCS_BUS_WRITE;
				nxt_st.lat_addr = st_ff.s2.addr;
				nxt_st.lat_data = st_ff.s2.data;
			end
			MCS_BUS_READ:
			begin
				if (st_ff.s2.rd_n)
					nxt_st.bus = MCS_BUS_IDLE_ST;
			end
			MCS_BUS_WRITE:
			begin
				// Data is sampled until the trailing edge of the strobe
				if (st_ff.s2.wr_n)
					nxt_st.bus = MCS_BUS_IDLE_ST;
				else
					nxt_st.lat_data = st_ff.s2.data;
			end
			default:
				nxt_st.bus = MCS_BUS_IDLE_ST;
		endcase
		// Command writes; both command registers are write only
		if (write_end && mcs_hit(st_ff.lat_addr, MCS_ADDR_TX_CMD))
			nxt_st.tx_cmd = st_ff.lat_data;
		if (write_end && mcs_hit(st_ff.lat_addr, MCS_ADDR_RX_CMD))
			nxt_st.rx_cmd = st_ff.lat_data;
		// Drive the bus for the whole read strobe; the address latched this edge
		// is used, so the first driven cycle already carries the right register
		nxt_st.doe = (nxt_st.bus == MCS_BUS_READ);
		nxt_st.dout = nxt_st.doe ? mcs_read_mux(nxt_st.lat_addr, tx_head, rx_stat)
			: MCS_BUS_IDLE;
		// Abort flag for the frame in progress; set beats clear
		if (rx_done)
			nxt_st.abort_lat = 1'b0;
		if (st_ff.s2.abort && st_ff.s2.cs)
			nxt_st.abort_lat = 1'b1;
		// Interrupts clear on a read of their status; events win
		if (tx_pop)
			nxt_st.tx_irq = 1'b0;
		if (tx_done && |(tx_cond & st_ff.tx_cmd[3:0]))
			nxt_st.tx_irq = 1'b1;
		if (rx_clear)
			nxt_st.rx_irq = 1'b0;
		if (rx_irq_hit && !rx_irq_disable)
			nxt_st.rx_irq = 1'b1;
		// Fault status handed to the host restarts reception
		if (rx_status_taken && rx_status_taken_err)
			nxt_st.rx_reset = 1'b1;
		nxt_st.tx_full = tx_full_w;
		nxt_st.tx_allow = !(cfg_tx_hold_when_full && tx_full_w);
		nxt_st.discard = rx_disc_w;
		nxt_st.word = rx_word_w;
		nxt_st.word_valid = rx_word_v_w;
	end

	// ==========================================================
	// Registers
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_ff <= '0;
			st_ff.s1 <= '{sel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
			st_ff.s2 <= '{sel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
			st_ff.bus <= MCS_BUS_IDLE_ST;
			st_ff.tx_cmd <= MCS_CMD_RESET;
			st_ff.rx_cmd <= MCS_CMD_RESET;
			st_ff.tx_allow <= 1'b1;
		end
		else
			st_ff <= nxt_st;
	end

	// ==========================================================
	// Outputs, all straight from flops
	assign command_status_bus_out = st_ff.dout;
	assign command_status_bus_oe = st_ff.doe;
	assign mii_select = st_ff.tx_cmd[MCS_TXC_MII];
	// Test bit passed on; host keeps it low in normal use
	assign test_mode = st_ff.tx_cmd[MCS_TXC_TEST];
	assign match_mode = st_ff.rx_cmd[7:MCS_RXC_MODE_LSB];
	assign tx_start_allowed = st_ff.tx_allow;
	assign tx_status_full = st_ff.tx_full;
	assign tx_irq = st_ff.tx_irq;
	assign rx_irq = st_ff.rx_irq;
	assign rx_discard = st_ff.discard;
	assign rx_status_word = st_ff.word;
	assign rx_status_word_valid = st_ff.word_valid;
	assign rx_section_reset = st_ff.rx_reset;
endmodule : mcs_regs

/* File: include/mcs_pkg.sv */
package mcs_pkg;
	// ==========================================================
	// Register port geometry and addresses
	localparam int MCS_ADDR_W = 6;
	localparam int MCS_DATA_W = 8;
	localparam logic [5:0] MCS_ADDR_TX_CMD = 6'h00;
	localparam logic [5:0] MCS_ADDR_RX_CMD = 6'h01;
	localparam logic [5:0] MCS_ADDR_TX_STAT = 6'h00;
	localparam logic [5:0] MCS_ADDR_RX_STAT = 6'h01;
	localparam logic [7:0] MCS_CMD_RESET = 8'h00;
	localparam logic [7:0] MCS_BUS_IDLE = 8'h00;
	localparam logic [6:0] MCS_STAT_CLEAR = 7'h00;
	// ==========================================================
	// Transmit command and status fields
	localparam int MCS_TXC_MII = 4;
	localparam int MCS_TXC_TEST = 7;
	localparam int MCS_TXS_UNDERFLOW = 0;
	localparam int MCS_TXS_COLL = 1;
	localparam int MCS_TXS_COLL16 = 2;
	localparam int MCS_TXS_OK = 3;
	localparam int MCS_TXS_CARRIER = 4;
	localparam int MCS_TXS_LATE = 6;
	localparam int MCS_STAT_NEW_N = 7;
	localparam int MCS_TX_DEPTH = 2;
	// ==========================================================
	// Receive command, status and appended status word fields
	localparam int MCS_RXC_OVERFLOW = 0;
	localparam int MCS_RXC_CRC = 1;
	localparam int MCS_RXC_OVERSIZE = 2;
	localparam int MCS_RXC_SHORT = 3;
	localparam int MCS_RXC_FIRST12 = 4;
	localparam int MCS_RXC_GOOD = 5;
	localparam int MCS_RXC_MODE_LSB = 6;
	localparam int MCS_RXS_OVERFLOW = 0;
	localparam int MCS_RXS_CRC = 1;
	localparam int MCS_RXS_SHORT = 3;
	localparam int MCS_RXS_OVERSIZE = 4;
	localparam int MCS_RXS_GOOD = 5;
	localparam int MCS_RXS_FIRST12 = 6;
	localparam int MCS_FSW_ABORT = 7;
	localparam int MCS_FSW_RDERR = 8;
	localparam int MCS_COUNT_W = 16;
	typedef enum logic [1:0] {
		MCS_MATCH_OFF = 2'b00,
		MCS_MATCH_ALL = 2'b01,
		MCS_MATCH_STATION = 2'b10,
		MCS_MATCH_MULTI = 2'b11
	} mcs_match_t;
	typedef enum logic [1:0] {
		MCS_BUS_IDLE_ST = 2'b00,
		MCS_BUS_READ = 2'b01,
		MCS_BUS_WRITE = 2'b10
	} mcs_bus_st_t;
endpackage : mcs_pkg

/* File: design/mcs_tx_status.sv */
module mcs_tx_status
	import mcs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic load,
	input wire logic [6:0] load_status,
	input wire logic skip_success,
	input wire logic pop,
	output logic [7:0] head,
	output logic full
);
	// ==========================================================
	// Two-entry status queue seen by the host as one register
	typedef struct packed {
		logic [MCS_TX_DEPTH-1:0][6:0] ent;
		logic [1:0] count;
		logic [6:0] last;
	} mcs_txq_t;

	mcs_txq_t st_ff;
	mcs_txq_t nxt_st;
	logic do_load;
	logic do_pop;

	assign full = (st_ff.count == 2'(MCS_TX_DEPTH));
	assign do_pop = pop && (st_ff.count != 2'h0);
	// Successful sends may be kept out of the queue entirely
	assign do_load = load && !full && !(skip_success && load_status[MCS_TXS_OK]);

	// Oldest entry first; once drained, repeat last value flagged old
	assign head = (st_ff.count != 2'h0) ? {1'b0, st_ff.ent[0]} : {1'b1, st_ff.last};

	always_comb
	begin
		nxt_st = st_ff;
		if (do_pop)
		begin
			nxt_st.last = st_ff.ent[0];
			nxt_st.ent[0] = st_ff.ent[1];
			nxt_st.ent[1] = MCS_STAT_CLEAR;
			nxt_st.count = st_ff.count - 2'h1;
		end
		if (do_load)
		begin
			nxt_st.ent[nxt_st.count[0]] = load_status;
			nxt_st.count = nxt_st.count + 2'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
endmodule : mcs_tx_status

/* File: design/mcs_rx_status.sv */
module mcs_rx_status
	import mcs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic pkt_done,
	input wire logic [6:0] pkt_status,
	input wire logic [MCS_COUNT_W-1:0] pkt_count,
	input wire logic abort_seen,
	input wire logic fifo_fault,
	input wire logic [7:0] rx_cmd,
	input wire logic clear,
	output logic [7:0] stat_reg,
	output logic discard,
	output logic [31:0] fifo_word,
	output logic word_valid,
	output logic irq_hit
);
	// ==========================================================
	// Status register, discard decision and appended status word
	typedef struct packed {
		logic [6:0] stat;
		logic new_f;
		logic discard;
		logic [31:0] word;
		logic word_valid;
		logic irq_hit;
	} mcs_rxs_t;

	mcs_rxs_t st_ff;
	mcs_rxs_t nxt_st;
	logic [5:0] cond;
	logic err_kept_out;
	logic drop;

	// Command enable order differs from status bit order
	function automatic logic [5:0] mcs_cond_map(input logic [6:0] s);
		mcs_cond_map = {s[MCS_RXS_GOOD], s[MCS_RXS_FIRST12], s[MCS_RXS_SHORT],
			s[MCS_RXS_OVERSIZE], s[MCS_RXS_CRC], s[MCS_RXS_OVERFLOW]};
	endfunction : mcs_cond_map

	assign cond = mcs_cond_map(pkt_status);
	// Error classes without acceptance enable force a discard
	assign err_kept_out = |(cond[MCS_RXC_SHORT:MCS_RXC_OVERFLOW]
		& ~rx_cmd[MCS_RXC_SHORT:MCS_RXC_OVERFLOW]);
	assign drop = err_kept_out || (rx_cmd[7:MCS_RXC_MODE_LSB] == MCS_MATCH_OFF);
	assign stat_reg = {~st_ff.new_f, st_ff.stat};
	assign discard = st_ff.discard;
	assign fifo_word = st_ff.word;
	assign word_valid = st_ff.word_valid;
	assign irq_hit = st_ff.irq_hit;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.discard = 1'b0;
		nxt_st.word_valid = 1'b0;
		nxt_st.irq_hit = 1'b0;
		if (clear)
		begin
			nxt_st.stat = MCS_STAT_CLEAR;
			nxt_st.new_f = 1'b0;
		end
		// New status wins over a clear landing in the same cycle
		if (pkt_done)
		begin
			if (!st_ff.new_f || clear)
			begin
				nxt_st.stat = pkt_status;
				nxt_st.new_f = 1'b1;
			end
			nxt_st.discard = drop;
			nxt_st.irq_hit = |(cond & rx_cmd[MCS_RXC_GOOD:MCS_RXC_OVERFLOW]);
			nxt_st.word_valid = !drop;
			// Same layout regardless of FIFO byte order
			nxt_st.word = {pkt_count, 7'h00, fifo_fault, abort_seen, pkt_status};
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
endmodule : mcs_rx_status

/* File: testbench/mcs_regs_sva.sv */
module mcs_regs_sva
	import mcs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [7:0] command_status_bus_out,
	input wire logic command_status_bus_oe,
	input wire logic rx_irq_disable,
	input wire logic cfg_tx_hold_when_full,
	input wire logic tx_done,
	input wire logic rx_done,
	input wire logic rx_status_taken,
	input wire logic rx_status_taken_err,
	input wire logic mii_select,
	input wire logic [1:0] match_mode,
	input wire logic tx_start_allowed,
	input wire logic tx_status_full,
	input wire logic rx_irq,
	input wire logic rx_discard,
	input wire logic rx_status_word_valid,
	input wire logic rx_section_reset
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dcb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	// ==========================================================
	// Transmit status queue and hold
	// Eight quiet read cycles let any pending pop land first
	property p_hold;
		(cfg_tx_hold_when_full && tx_status_full && rd_n) [*8] |-> !tx_start_allowed;
	endproperty
	a_hold: assert property (p_hold) else $error("transmit not held while full");
	property p_go;
		!cfg_tx_hold_when_full [*2] |-> tx_start_allowed;
	endproperty
	a_go: assert property (p_go) else $error("transmit held without hold mode");
	property p_full;
		(!tx_done && rd_n) [*8] |=> $stable(tx_status_full);
	endproperty
	a_full: assert property (p_full) else $error("full flag moved without cause");
	// ==========================================================
	// Receive status path
	property p_disc;
		rx_discard |-> $past(rx_done, 2);
	endproperty
	a_disc: assert property (p_disc) else $error("discard without packet end");
	property p_valid;
		rx_status_word_valid |-> $past(rx_done, 2);
	endproperty
	a_valid: assert property (p_valid) else $error("status word without packet end");
	property p_srst;
		rx_status_taken && rx_status_taken_err |=> rx_section_reset;
	endproperty
	a_srst: assert property (p_srst) else $error("no receive reset after fault");
	property p_nirq;
		rx_irq_disable [*3] |-> !$rose(rx_irq);
	endproperty
	a_nirq: assert property (p_nirq) else $error("receive interrupt while disabled");
	// ==========================================================
	// Register port
	property p_idle;
		!command_status_bus_oe |-> command_status_bus_out == MCS_BUS_IDLE;
	endproperty
	a_idle: assert property (p_idle) else $error("bus data while not driving");
	property p_cmd;
		(wr_n && rd_n) [*6] |=> $stable(mii_select) && $stable(match_mode);
	endproperty
	a_cmd: assert property (p_cmd) else $error("command changed without write");
endmodule : mcs_regs_sva

bind mcs_regs mcs_regs_sva mcs_regs_sva_inst (.ref_clk, .resetn, .rd_n, .wr_n,
	.command_status_bus_out, .command_status_bus_oe, .rx_irq_disable, .cfg_tx_hold_when_full,
	.tx_done, .rx_done, .rx_status_taken, .rx_status_taken_err, .mii_select, .match_mode,
	.tx_start_allowed, .tx_status_full, .rx_irq, .rx_discard, .rx_status_word_valid,
	.rx_section_reset);

/* File: testbench/mcs_host_model.sv */
module mcs_host_model
	import mcs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [7:0] command_status_bus_out,
	input wire logic command_status_bus_oe,
	output logic register_port_select_n,
	output logic rd_n,
	output logic wr_n,
	output logic [5:0] addr,
	output logic [7:0] command_status_bus_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Idle host pins
	initial
	begin
		{register_port_select_n, rd_n, wr_n} = 3'h7;
		addr = 6'h3f;
		command_status_bus_in = 8'h5a;
	end
	// Data outlives the strobe, the commit lands late; released lines invert
	task wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		register_port_select_n <= 1'b0;
		wr_n <= 1'b0;
		addr <= a;
		command_status_bus_in <= d;
		repeat (4) @(negedge ref_clk);
		wr_n <= 1'b1;
		repeat (4) @(negedge ref_clk);
		register_port_select_n <= 1'b1;
		addr <= ~a;
		command_status_bus_in <= ~d;
		repeat (3) @(negedge ref_clk);
	endtask : wr
	// Read held until the bus is driven, bounded wait
	task rd(input logic [5:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		register_port_select_n <= 1'b0;
		rd_n <= 1'b0;
		addr <= a;
		for (int i = 0; i < 12 && command_status_bus_oe !== 1'b1; i++)
			@(negedge ref_clk);
		d = command_status_bus_out;
		rd_n <= 1'b1;
		register_port_select_n <= 1'b1;
		addr <= ~a;
		repeat (6) @(negedge ref_clk);
	endtask : rd
endmodule : mcs_host_model

/* File: testbench/mcs_regs_tb.sv */
module mcs_regs_tb
	import mcs_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic resetn, register_port_select_n, rd_n, wr_n, command_status_bus_oe, mii_select;
	logic [5:0] addr;
	logic [7:0] command_status_bus_in, command_status_bus_out, g, d, tcmd, rcmd;
	logic receive_abort_in, carrier_sense_in, rx_irq_disable, cfg_tx_hold_when_full;
	logic cfg_skip_success_status, tx_done, rx_done, rx_fifo_fault, rx_status_taken;
	logic rx_status_taken_err, test_mode, tx_start_allowed, tx_status_full, tx_irq, rx_irq;
	logic rx_discard, rx_status_word_valid, rx_section_reset, k, ab, rx_new, tirq_m, rirq_m;
	logic [6:0] tx_done_status, rx_done_status, s, tx_last, rx_hold;
	logic [15:0] rx_byte_count;
	logic [1:0] match_mode;
	logic [31:0] rx_status_word, r;
	logic [31:0] seed = 32'h9af6;
	logic [7:0] txq[$];
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;

	mcs_regs mcs_regs_inst (.ref_clk, .resetn, .register_port_select_n, .rd_n, .wr_n, .addr,
		.command_status_bus_in, .command_status_bus_out, .command_status_bus_oe,
		.receive_abort_in, .carrier_sense_in, .rx_irq_disable, .cfg_tx_hold_when_full,
		.cfg_skip_success_status, .tx_done, .tx_done_status, .rx_done, .rx_done_status,
		.rx_byte_count, .rx_fifo_fault, .rx_status_taken, .rx_status_taken_err, .mii_select,
		.test_mode, .match_mode, .tx_start_allowed, .tx_status_full, .tx_irq, .rx_irq,
		.rx_discard, .rx_status_word, .rx_status_word_valid, .rx_section_reset);
	mcs_host_model mcs_host_model_inst (.ref_clk, .command_status_bus_out,
		.command_status_bus_oe, .register_port_select_n, .rd_n, .wr_n, .addr,
		.command_status_bus_in);

	// ==========================================================
	// Clock, hang guard, helpers
	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			failures++;
			report_and_stop();
		end
	end
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task report_and_stop();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	task rdc(input logic [5:0] a, input logic [7:0] e);
		mcs_host_model_inst.rd(a, g);
		chk(g, e);
	endtask : rdc
	// ==========================================================
	// Transmit model: two entries, old read repeats last popped value
	task txev(input int c, input logic [6:0] o, input logic [6:0] m);
		for (int i = 0; i < c; i++)
		begin
			r = rnd();
			s = (r[6:0] & m) | o;
			tx_done <= 1'b1;
			tx_done_status <= s;
			if (!(cfg_skip_success_status && s[3]) && txq.size() < 2)
				txq.push_back({1'b0, s});
			tirq_m |= |({s[3], s[2] | s[4] | s[6], s[1], s[0]} & tcmd[3:0]);
			@(negedge ref_clk);
		end
		tx_done <= 1'b0;
		repeat (2) @(negedge ref_clk);
	endtask : txev
	task txrd();
		d = {1'b1, tx_last};
		if (txq.size() > 0)
		begin
			d = txq.pop_front();
			tx_last = d[6:0];
			tirq_m = 1'b0;
		end
		rdc(MCS_ADDR_TX_STAT, d);
		chk(tx_irq, tirq_m);
	endtask : txrd
	// Receive model: status held while new, word only for kept packets
	task rxev(input logic f);
		r = rnd();
		s = r[6:0];
		k = (rcmd[7:6] != 2'b00) && !(|({s[3], s[4], s[1], s[0]} & ~rcmd[3:0]));
		{rx_done, rx_done_status, rx_byte_count, rx_fifo_fault} <= {1'b1, s, r[31:16], f};
		@(negedge ref_clk);
		rx_done <= 1'b0;
		// Discard and valid stand one cycle only; look while they do
		@(negedge ref_clk);
		chk(rx_discard, !k);
		chk(rx_status_word_valid, k);
		if (k)
			chk(rx_status_word, {r[31:16], 7'h00, f, ab, s});
		if (!rx_new)
			{rx_new, rx_hold} = {1'b1, s};
		rirq_m |= !rx_irq_disable && (|({s[5], s[6], s[3], s[4], s[1], s[0]} & rcmd[5:0]));
		chk(rx_irq, rirq_m);
	endtask : rxev

	// ==========================================================
	// Main sequence
	initial
	begin
		{resetn, receive_abort_in, carrier_sense_in, rx_irq_disable, cfg_tx_hold_when_full} = '0;
		{cfg_skip_success_status, tx_done, rx_done, rx_fifo_fault, rx_status_taken} = '0;
		{rx_status_taken_err, tx_done_status, rx_done_status, rx_byte_count} = '0;
		{tx_last, rx_new, tirq_m, rirq_m, ab} = '0;
		repeat (20) @(negedge ref_clk);
		resetn <= 1'b1;
		rdc(MCS_ADDR_TX_STAT, 8'h80);
		rdc(MCS_ADDR_RX_STAT, 8'h80);
		rdc(6'h05, 8'h00);
		chk(tx_start_allowed, 1'b1);
		// Back to back attempts: third dropped, hold engages
		tcmd = 8'h1f;
		mcs_host_model_inst.wr(MCS_ADDR_TX_CMD, tcmd);
		chk(mii_select, 1'b1);
		chk(test_mode, 1'b0);
		cfg_tx_hold_when_full <= 1'b1;
		txev(3, 7'h00, 7'h7f);
		// Sit full and quiet long enough for the hold check to engage
		repeat (8) @(negedge ref_clk);
		chk(tx_status_full, 1'b1);
		chk(tx_start_allowed, 1'b0);
		chk(tx_irq, tirq_m);
		repeat (3) txrd();
		chk(tx_start_allowed, 1'b1);
		// Successful attempts skipped, others still loaded
		cfg_skip_success_status <= 1'b1;
		@(negedge ref_clk);
		txev(2, 7'h08, 7'h7f);
		txev(1, 7'h00, 7'h77);
		repeat (2) txrd();
		cfg_skip_success_status <= 1'b0;
		// All masks clear: no interrupt
		tcmd = 8'h00;
		mcs_host_model_inst.wr(MCS_ADDR_TX_CMD, tcmd);
		chk(mii_select, 1'b0);
		txev(1, 7'h01, 7'h7f);
		chk(tx_irq, 1'b0);
		txrd();
		// Every match mode, random enables, abort on odd turns, fault last
		for (int i = 0; i < 8; i++)
		begin
			r = rnd();
			rcmd = {i[1:0], r[5:0]};
			rx_irq_disable <= r[8];
			mcs_host_model_inst.wr(MCS_ADDR_RX_CMD, rcmd);
			chk(match_mode, i[1:0]);
			ab = i[0];
			// Abort without carrier on even turns must not be flagged
			{receive_abort_in, carrier_sense_in} <= {r[9] | ab, ab};
			repeat (3) @(negedge ref_clk);
			{receive_abort_in, carrier_sense_in} <= 2'b00;
			repeat (3) @(negedge ref_clk);
			rxev(i == 7);
			ab = 1'b0;
			rxev(1'b0);
			rdc(MCS_ADDR_RX_STAT, {1'b0, rx_hold});
			{rx_new, rirq_m} = 2'b00;
			chk(rx_irq, 1'b0);
			rdc(MCS_ADDR_RX_STAT, 8'h80);
			{rx_status_taken, rx_status_taken_err} <= {1'b1, i == 7};
			@(negedge ref_clk);
			chk(rx_section_reset, i == 7);
			{rx_status_taken, rx_status_taken_err} <= 2'b00;
		end
		report_and_stop();
	end
endmodule : mcs_regs_tb
